// ### tocmc_pkg.sv
// Package for the timer output-compare mode configuration block
package tocmc_pkg;
	// Register offsets (byte addresses)
	localparam logic [7:0] TOCMC_MODE_OFF = 8'h18;
	localparam logic [7:0] TOCMC_ENAB_OFF = 8'h20;
	localparam logic [7:0] TOCMC_CMP1_OFF = 8'h34;
	localparam logic [7:0] TOCMC_CMP2_OFF = 8'h38;
	localparam logic [7:0] TOCMC_CTRL_OFF = 8'h3c;
	localparam logic [7:0] TOCMC_STAT_OFF = 8'h40;
	// Mode register field positions
	localparam int TOCMC_CH1_DIR_LSB = 0;
	localparam int TOCMC_CH1_FAST_BIT = 2;
	localparam int TOCMC_CH1_PRE_BIT = 3;
	localparam int TOCMC_CH1_MODE_LSB = 4;
	localparam int TOCMC_CH2_DIR_LSB = 8;
	localparam int TOCMC_CH2_FAST_BIT = 10;
	localparam int TOCMC_CH2_PRE_BIT = 11;
	localparam int TOCMC_CH2_MODE_LSB = 12;
	// Reset values and the locking protection level
	localparam logic [15:0] TOCMC_MODE_RST = 16'h0000;
	localparam logic [15:0] TOCMC_CMP_RST = 16'h0000;
	localparam logic [1:0] TOCMC_PROT_LOCKED = 2'h3;
	// Direction select encodings
	localparam logic [1:0] TOCMC_DIR_OUT = 2'h0;
	// Compare modes
	typedef enum logic [2:0] {
		TOCMC_FREEZE = 3'h0,
		TOCMC_SET_MATCH = 3'h1,
		TOCMC_CLR_MATCH = 3'h2,
		TOCMC_TOG_MATCH = 3'h3,
		TOCMC_FORCE_LOW = 3'h4,
		TOCMC_FORCE_HIGH = 3'h5,
		TOCMC_PWM1 = 3'h6,
		TOCMC_PWM2 = 3'h7
	} tocmc_mode_t;
	// Per-channel configuration
	typedef struct packed {
		tocmc_mode_t mode;
		logic preload;
		logic fast;
		logic [1:0] dir;
	} tocmc_chan_t;
	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} tocmc_bus_t;
endpackage : tocmc_pkg

// ### tocmc_top.sv
// Output-compare mode configuration and reference generation for two channels
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - Ch1 direction 00 output, 01 input 1, 10 input 2, 11 trigger input.
// - Ch1 direction writable only while ch1 enable bit is clear.
// - Ch1 fast enable bit 2 reacts to trigger event without delay.
// - Preload off: compare value write is used at next comparison.
// - Preload on: write goes to shadow, copied on update event.
// - Protection level 3 with output channel locks preload and mode bits.
// - Mode 000 freezes the reference output.
// - Mode 001 sets reference high on match.
// - Mode 010 sets reference low on match.
// - Mode 011 toggles reference on match.
// - Mode 100 forces reference low.
// - Mode 101 forces reference high.
// - Mode 110 high while counter below compare value.
// - Mode 111 high while counter above compare value.
// - PWM level follows compare result, also right after leaving freeze.
// - Ch2 direction 00 output, 01 input 2, 10 input 1, 11 trigger input.
// - Ch2 direction writable only while ch2 enable bit is clear.
// - Ch2 fields at 10, 11, 14:12; bits 7 and 15 reserved.
module tocmc_top
	import tocmc_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire tocmc_bus_t bus_in,
	output logic [15:0] rdata_out,
	input wire logic update_event_in,
	input wire logic trigger_event_in,
	input wire logic [15:0] counter_value_in,
	input wire logic [1:0] protection_level_in,
	input wire logic timer_input_1_in,
	input wire logic timer_input_2_in,
	input wire logic trigger_controller_input_in,
	output logic ch1_reference_output_out,
	output logic ch2_reference_output_out,
	output logic ch1_capture_input_out,
	output logic ch2_capture_input_out
);

	tocmc_chan_t ch1_cfg_r;
	tocmc_chan_t ch2_cfg_r;
	logic ch1_enable_bit_r;
	logic ch2_enable_bit_r;
	logic single_pulse_enable_r;
	logic [15:0] ch1_compare_value_r;
	logic [15:0] ch2_compare_value_r;
	logic [15:0] ch1_shadow_r;
	logic [15:0] ch2_shadow_r;
	logic [2:0] src1_sync_r;
	logic [2:0] src2_sync_r;
	logic [2:0] srct_sync_r;
	logic src1_lvl_r;
	logic src2_lvl_r;
	logic srct_lvl_r;
	logic [15:0] mode_word;
	logic wr_mode;
	logic lock1;
	logic lock2;
	logic ch1_ref_nxt;
	logic ch2_ref_nxt;

	// Next reference level for one channel; trigger forces a fast match when enabled
	function automatic logic ref_next(input tocmc_chan_t cfg, input logic cur,
		input logic [15:0] count, input logic [15:0] cmp, input logic trig);
		logic match;
		match = (count == cmp) || (cfg.fast && trig);
		case (cfg.mode)
			TOCMC_FREEZE: ref_next = cur;
			TOCMC_SET_MATCH: ref_next = match ? 1'b1 : cur;
			TOCMC_CLR_MATCH: ref_next = match ? 1'b0 : cur;
			TOCMC_TOG_MATCH: ref_next = match ? ~cur : cur;
			TOCMC_FORCE_LOW: ref_next = 1'b0;
			TOCMC_FORCE_HIGH: ref_next = 1'b1;
			TOCMC_PWM1: ref_next = (count < cmp);
			default: ref_next = (count > cmp);
		endcase
	endfunction : ref_next

	// Capture source selection; direction swaps the two timer inputs per channel
	function automatic logic cap_sel(input logic [1:0] dir, input logic own,
		input logic other, input logic trig_src);
		case (dir)
			2'h1: cap_sel = own;
			2'h2: cap_sel = other;
			2'h3: cap_sel = trig_src;
			default: cap_sel = 1'b0;
		endcase
	endfunction : cap_sel

	assign wr_mode = bus_in.wr && (bus_in.addr == TOCMC_MODE_OFF);
	assign mode_word = bus_in.wdata;
	// Lock applies only while the channel is an output
	assign lock1 = (protection_level_in == TOCMC_PROT_LOCKED) && (ch1_cfg_r.dir == TOCMC_DIR_OUT);
	assign lock2 = (protection_level_in == TOCMC_PROT_LOCKED) && (ch2_cfg_r.dir == TOCMC_DIR_OUT);

	// Channel 1 configuration fields
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ch1_cfg_r <= tocmc_chan_t'(TOCMC_MODE_RST[6:0]);
		end
		else if (wr_mode)
		begin
			if (!ch1_enable_bit_r)
			begin
				ch1_cfg_r.dir <= mode_word[TOCMC_CH1_DIR_LSB +: 2];
			end
			ch1_cfg_r.fast <= mode_word[TOCMC_CH1_FAST_BIT];
			if (!lock1)
			begin
				ch1_cfg_r.preload <= mode_word[TOCMC_CH1_PRE_BIT];
				ch1_cfg_r.mode <= tocmc_mode_t'(mode_word[TOCMC_CH1_MODE_LSB +: 3]);
			end
		end
	end

	// Channel 2 configuration fields, same behaviour as channel 1
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ch2_cfg_r <= tocmc_chan_t'(TOCMC_MODE_RST[14:8]);
		end
		else if (wr_mode)
		begin
			if (!ch2_enable_bit_r)
			begin
				ch2_cfg_r.dir <= mode_word[TOCMC_CH2_DIR_LSB +: 2];
			end
			ch2_cfg_r.fast <= mode_word[TOCMC_CH2_FAST_BIT];
			if (!lock2)
			begin
				ch2_cfg_r.preload <= mode_word[TOCMC_CH2_PRE_BIT];
				ch2_cfg_r.mode <= tocmc_mode_t'(mode_word[TOCMC_CH2_MODE_LSB +: 3]);
			end
		end
	end

	// Channel enables live in the enable register, the single-pulse flag in the control register
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ch1_enable_bit_r <= 1'b0;
			ch2_enable_bit_r <= 1'b0;
			single_pulse_enable_r <= 1'b0;
		end
		else if (bus_in.wr && (bus_in.addr == TOCMC_ENAB_OFF))
		begin
			ch1_enable_bit_r <= bus_in.wdata[0];
			ch2_enable_bit_r <= bus_in.wdata[1];
		end
		else if (bus_in.wr && (bus_in.addr == TOCMC_CTRL_OFF))
		begin
			single_pulse_enable_r <= bus_in.wdata[0];
		end
	end

	// Shadow compare values always take software writes
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ch1_shadow_r <= TOCMC_CMP_RST;
			ch2_shadow_r <= TOCMC_CMP_RST;
		end
		else
		begin
			if (bus_in.wr && (bus_in.addr == TOCMC_CMP1_OFF))
			begin
				ch1_shadow_r <= bus_in.wdata;
			end
			if (bus_in.wr && (bus_in.addr == TOCMC_CMP2_OFF))
			begin
				ch2_shadow_r <= bus_in.wdata;
			end
		end
	end

	// Active compare values: direct write without preload, else copy on update
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ch1_compare_value_r <= TOCMC_CMP_RST;
			ch2_compare_value_r <= TOCMC_CMP_RST;
		end
		else
		begin
			if (!ch1_cfg_r.preload && bus_in.wr && (bus_in.addr == TOCMC_CMP1_OFF))
			begin
				ch1_compare_value_r <= bus_in.wdata;
			end
			else if (ch1_cfg_r.preload && update_event_in)
			begin
				ch1_compare_value_r <= ch1_shadow_r;
			end
			if (!ch2_cfg_r.preload && bus_in.wr && (bus_in.addr == TOCMC_CMP2_OFF))
			begin
				ch2_compare_value_r <= bus_in.wdata;
			end
			else if (ch2_cfg_r.preload && update_event_in)
			begin
				ch2_compare_value_r <= ch2_shadow_r;
			end
		end
	end

	assign ch1_ref_nxt = ref_next(ch1_cfg_r, ch1_reference_output_out, counter_value_in,
		ch1_compare_value_r, trigger_event_in);
	assign ch2_ref_nxt = ref_next(ch2_cfg_r, ch2_reference_output_out, counter_value_in,
		ch2_compare_value_r, trigger_event_in);

	// Reference outputs; PWM levels are recomputed every cycle so leaving freeze acts at once
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ch1_reference_output_out <= 1'b0;
			ch2_reference_output_out <= 1'b0;
		end
		else
		begin
			ch1_reference_output_out <= ch1_ref_nxt;
			ch2_reference_output_out <= ch2_ref_nxt;
		end
	end

	// Input pins pass three flops; a change counts once stages two and three agree
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			src1_sync_r <= 3'h0;
			src2_sync_r <= 3'h0;
			srct_sync_r <= 3'h0;
			src1_lvl_r <= 1'b0;
			src2_lvl_r <= 1'b0;
			srct_lvl_r <= 1'b0;
		end
		else
		begin
			src1_sync_r <= {src1_sync_r[1:0], timer_input_1_in};
			src2_sync_r <= {src2_sync_r[1:0], timer_input_2_in};
			srct_sync_r <= {srct_sync_r[1:0], trigger_controller_input_in};
			if (src1_sync_r[1] == src1_sync_r[2])
			begin
				src1_lvl_r <= src1_sync_r[2];
			end
			if (src2_sync_r[1] == src2_sync_r[2])
			begin
				src2_lvl_r <= src2_sync_r[2];
			end
			if (srct_sync_r[1] == srct_sync_r[2])
			begin
				srct_lvl_r <= srct_sync_r[2];
			end
		end
	end

	// Capture input routing; low while the channel is an output
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ch1_capture_input_out <= 1'b0;
			ch2_capture_input_out <= 1'b0;
		end
		else
		begin
			ch1_capture_input_out <= cap_sel(ch1_cfg_r.dir, src1_lvl_r, src2_lvl_r, srct_lvl_r);
			ch2_capture_input_out <= cap_sel(ch2_cfg_r.dir, src2_lvl_r, src1_lvl_r, srct_lvl_r);
		end
	end

	// Read port: data one cycle after the strobe, unmapped reads give zero
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rdata_out <= 16'h0000;
		end
		else if (!bus_in.rd)
		begin
			rdata_out <= 16'h0000;
		end
		else if (bus_in.addr == TOCMC_MODE_OFF)
		begin
			rdata_out <= {1'b0, ch2_cfg_r, 1'b0, ch1_cfg_r};
		end
		else if (bus_in.addr == TOCMC_ENAB_OFF)
		begin
			rdata_out <= {14'h0000, ch2_enable_bit_r, ch1_enable_bit_r};
		end
		else if (bus_in.addr == TOCMC_CMP1_OFF)
		begin
			rdata_out <= ch1_compare_value_r;
		end
		else if (bus_in.addr == TOCMC_CMP2_OFF)
		begin
			rdata_out <= ch2_compare_value_r;
		end
		else if (bus_in.addr == TOCMC_CTRL_OFF)
		begin
			rdata_out <= {15'h0000, single_pulse_enable_r};
		end
		else if (bus_in.addr == TOCMC_STAT_OFF)
		begin
			rdata_out <= {14'h0000, ch2_reference_output_out, ch1_reference_output_out};
		end
		else
		begin
			rdata_out <= 16'h0000;
		end
	end

	// Direction stays put across a write while the channel is enabled
	ch1_dir_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ch1_enable_bit_r |=> $stable(ch1_cfg_r.dir))
		else $error("ch1 direction changed while enabled");
	ch2_dir_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ch2_enable_bit_r |=> $stable(ch2_cfg_r.dir))
		else $error("ch2 direction changed while enabled");
	// Locked channel keeps mode and preload
	ch1_lock_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		lock1 |=> $stable(ch1_cfg_r.mode) && $stable(ch1_cfg_r.preload))
		else $error("ch1 mode changed under protection");
	// Preloaded value only moves on update event
	preload_wait_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(ch1_cfg_r.preload && !update_event_in) |=> $stable(ch1_compare_value_r))
		else $error("ch1 compare value moved without update");
	direct_write_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(!ch1_cfg_r.preload && bus_in.wr && bus_in.addr == TOCMC_CMP1_OFF)
		|=> ch1_compare_value_r == $past(bus_in.wdata))
		else $error("ch1 direct compare write lost");
	// Freeze holds the reference output
	freeze_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ch1_cfg_r.mode == TOCMC_FREEZE |=> $stable(ch1_reference_output_out))
		else $error("ch1 reference moved in freeze");
	set_match_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(ch1_cfg_r.mode == TOCMC_SET_MATCH && counter_value_in == ch1_compare_value_r)
		|=> ch1_reference_output_out)
		else $error("ch1 reference not set on match");
	force_low_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ch1_cfg_r.mode == TOCMC_FORCE_LOW |=> !ch1_reference_output_out)
		else $error("ch1 reference not forced low");
	pwm_one_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ch1_cfg_r.mode == TOCMC_PWM1
		|=> ch1_reference_output_out == ($past(counter_value_in) < $past(ch1_compare_value_r)))
		else $error("ch1 PWM mode 1 level wrong");
	toggle_match_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(ch2_cfg_r.mode == TOCMC_TOG_MATCH && counter_value_in == ch2_compare_value_r)
		|=> ch2_reference_output_out != $past(ch2_reference_output_out))
		else $error("ch2 reference did not toggle");
	// Locked channel 2 keeps mode and preload as well
	ch2_lock_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		lock2 |=> $stable(ch2_cfg_r.mode) && $stable(ch2_cfg_r.preload))
		else $error("ch2 mode changed under protection");
	clr_match_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(ch1_cfg_r.mode == TOCMC_CLR_MATCH && counter_value_in == ch1_compare_value_r)
		|=> !ch1_reference_output_out)
		else $error("ch1 reference not cleared on match");
	force_high_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ch1_cfg_r.mode == TOCMC_FORCE_HIGH |=> ch1_reference_output_out)
		else $error("ch1 reference not forced high");
	pwm_two_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ch1_cfg_r.mode == TOCMC_PWM2
		|=> ch1_reference_output_out == ($past(counter_value_in) > $past(ch1_compare_value_r)))
		else $error("ch1 PWM mode 2 level wrong");
	// A fast-enabled trigger acts as a match without waiting for the counter
	fast_match_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(ch1_cfg_r.mode == TOCMC_SET_MATCH && ch1_cfg_r.fast && trigger_event_in)
		|=> ch1_reference_output_out)
		else $error("ch1 fast trigger did not act");
	// Capture path stays quiet while channel 1 drives its output
	ch1_out_quiet_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ch1_cfg_r.dir == TOCMC_DIR_OUT |=> !ch1_capture_input_out)
		else $error("ch1 capture input active while output");

endmodule : tocmc_top

// ### tocmc_tb.sv
// Self-checking bench for the output-compare mode configuration block
`timescale 1ns/1ps
module testbench;
	import tocmc_pkg::*;
	typedef struct {logic ch; logic [2:0] md; logic [15:0] cv; logic ex;} tocmc_row_t;
	logic clk, rst_n, up, trg, pin1, pin2, pinx, r1, r2, c1, c2;
	logic [15:0] ctr_val, rdata;
	logic [1:0] prot;
	tocmc_bus_t bus;
	int bad_count, compares, cyc;
	// Rows run in order: freeze rows depend on the level left by the row before
	tocmc_row_t rows [14] = '{
		'{1'b0, 3'h5, 16'h0005, 1'b1}, '{1'b0, 3'h4, 16'h0005, 1'b0},
		'{1'b0, 3'h1, 16'h000a, 1'b1}, '{1'b0, 3'h0, 16'h0014, 1'b1},
		'{1'b0, 3'h2, 16'h000a, 1'b0}, '{1'b0, 3'h0, 16'h0005, 1'b0},
		'{1'b0, 3'h6, 16'h0005, 1'b1}, '{1'b0, 3'h6, 16'h000a, 1'b0},
		'{1'b0, 3'h7, 16'h000a, 1'b0}, '{1'b0, 3'h7, 16'h000b, 1'b1},
		'{1'b1, 3'h6, 16'h0009, 1'b1}, '{1'b1, 3'h7, 16'h0009, 1'b0},
		'{1'b1, 3'h1, 16'h000a, 1'b1}, '{1'b1, 3'h4, 16'h0009, 1'b0}};

	tocmc_top uut (.ref_clk_in(clk), .rst_n_in(rst_n), .bus_in(bus), .rdata_out(rdata),
		.update_event_in(up), .trigger_event_in(trg), .counter_value_in(ctr_val),
		.protection_level_in(prot), .timer_input_1_in(pin1), .timer_input_2_in(pin2),
		.trigger_controller_input_in(pinx), .ch1_reference_output_out(r1),
		.ch2_reference_output_out(r2), .ch1_capture_input_out(c1), .ch2_capture_input_out(c2));

	// Clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic end_of_test;
		$display("Compares %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			$display("Error at %0t: timeout", $time);
			end_of_test();
		end
	end

	task automatic chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: level %b, expected %b", $time, got, exp);
		end
	endtask : chk_bit

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask : chk_word

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask : wr

	// Read data stands only in the cycle after the strobe, so sample there
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1;
		d = rdata;
	endtask : rd

	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask : settle

	task automatic count_to(input logic [15:0] v);
		@(posedge clk);
		ctr_val <= v;
	endtask : count_to

	// Pins need several cycles through the synchronisers
	task automatic route(input logic [15:0] w, input logic [2:0] p, input logic e1, e2);
		wr(TOCMC_MODE_OFF, w);
		@(posedge clk);
		{pinx, pin2, pin1} <= p;
		repeat (8) @(posedge clk);
		#1;
		chk_bit(c1, e1);
		chk_bit(c2, e2);
	endtask : route

	initial
	begin : main
		logic [15:0] d;
		rst_n = 1'b0;
		bus = '0;
		{up, trg, pin1, pin2, pinx} = 5'h00;
		ctr_val = 16'h0000;
		prot = 2'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rd(TOCMC_MODE_OFF, d);
		chk_word(d, TOCMC_MODE_RST);
		chk_word({12'h000, r1, r2, c1, c2}, 16'h0000);
		wr(8'h7c, 16'hffff);
		rd(8'h7c, d);
		chk_word(d, 16'h0000);
		wr(TOCMC_CTRL_OFF, 16'h0001);
		wr(TOCMC_CMP1_OFF, 16'h000a);
		wr(TOCMC_CMP2_OFF, 16'h000a);
		// Ordinary mode cases on both channels
		foreach (rows[i])
		begin
			count_to(rows[i].cv);
			if (rows[i].ch)
				wr(TOCMC_MODE_OFF, {1'b0, rows[i].md, 12'h000});
			else
				wr(TOCMC_MODE_OFF, {9'h000, rows[i].md, 4'h0});
			settle();
			chk_bit(rows[i].ch ? r2 : r1, rows[i].ex);
		end
		// Reserved bits read as zero
		wr(TOCMC_MODE_OFF, 16'hffff);
		rd(TOCMC_MODE_OFF, d);
		chk_word(d, 16'h7f7f);
		// Direction locked per channel while its enable bit is set
		wr(TOCMC_MODE_OFF, 16'h0000);
		wr(TOCMC_ENAB_OFF, 16'h0001);
		wr(TOCMC_MODE_OFF, 16'h0303);
		rd(TOCMC_MODE_OFF, d);
		chk_word(d, 16'h0300);
		wr(TOCMC_ENAB_OFF, 16'h0002);
		wr(TOCMC_MODE_OFF, 16'h0101);
		rd(TOCMC_MODE_OFF, d);
		chk_word(d, 16'h0301);
		rd(TOCMC_ENAB_OFF, d);
		chk_word(d, 16'h0002);
		wr(TOCMC_ENAB_OFF, 16'h0000);
		route(16'h0201, 3'b001, 1'b1, 1'b1);
		route(16'h0201, 3'b010, 1'b0, 1'b0);
		route(16'h0102, 3'b010, 1'b1, 1'b1);
		route(16'h0102, 3'b001, 1'b0, 1'b0);
		route(16'h0303, 3'b100, 1'b1, 1'b1);
		route(16'h0000, 3'b111, 1'b0, 1'b0);
		// Level 3 locks preload and mode of an output channel, fast bit stays free
		wr(TOCMC_MODE_OFF, 16'h0008);
		@(posedge clk);
		prot <= TOCMC_PROT_LOCKED;
		wr(TOCMC_MODE_OFF, 16'h3854);
		rd(TOCMC_MODE_OFF, d);
		chk_word(d, 16'h000c);
		@(posedge clk);
		prot <= 2'h0;
		// Direct and buffered compare value
		wr(TOCMC_MODE_OFF, 16'h0060);
		count_to(16'h000c);
		settle();
		chk_bit(r1, 1'b0);
		wr(TOCMC_CMP1_OFF, 16'h0014);
		settle();
		chk_bit(r1, 1'b1);
		wr(TOCMC_MODE_OFF, 16'h0068);
		wr(TOCMC_CMP1_OFF, 16'h0005);
		settle();
		chk_bit(r1, 1'b1);
		@(posedge clk);
		up <= 1'b1;
		@(posedge clk);
		up <= 1'b0;
		settle();
		chk_bit(r1, 1'b0);
		rd(TOCMC_CMP1_OFF, d);
		chk_word(d, 16'h0005);
		// Trigger counts as a match only with fast enable
		wr(TOCMC_MODE_OFF, 16'h0040);
		wr(TOCMC_CMP1_OFF, 16'h000a);
		count_to(16'h0005);
		for (int k = 0; k < 2; k++)
		begin
			wr(TOCMC_MODE_OFF, k ? 16'h0014 : 16'h0010);
			@(posedge clk);
			trg <= 1'b1;
			@(posedge clk);
			trg <= 1'b0;
			settle();
			chk_bit(r1, k[0]);
		end
		// Single-cycle matches toggle once each
		// Channel 2 starts low from freeze, so it toggles in step opposite to channel 1
		wr(TOCMC_MODE_OFF, 16'h3030);
		for (int k = 0; k < 2; k++)
		begin
			count_to(16'h000a);
			count_to(16'h0005);
			settle();
			chk_bit(r1, k[0]);
			chk_bit(r2, !k[0]);
		end
		rd(TOCMC_STAT_OFF, d);
		chk_word(d, 16'h0001);
		rd(TOCMC_CMP2_OFF, d);
		chk_word(d, 16'h000a);
		rd(TOCMC_CTRL_OFF, d);
		chk_word(d, 16'h0001);
		// Reset in mid-run clears configuration and outputs
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(TOCMC_MODE_OFF, d);
		chk_word(d, TOCMC_MODE_RST);
		chk_bit(r1, 1'b0);
		chk_bit(r2, 1'b0);
		end_of_test();
	end
endmodule : testbench
